// ===== vvc_regs.svh
// Offsets, field positions, reset values and credit table for the capability bank.
// Assumes byte offsets relative to each structure base, dword-aligned.
`ifndef VVC_REGS_SVH
`define VVC_REGS_SVH

// Virtual channel structure, byte offsets from its base
`define VVC_VC_HDR_OFF        12'h000
`define VVC_VC_PORT_CAP1_OFF  12'h004
`define VVC_VC_PORT_CAP2_OFF  12'h008
`define VVC_VC_PORT_CTRL_OFF  12'h00C
`define VVC_VC_RES_CAP_OFF    12'h010

// Vendor-specific structure, byte offsets from its base
`define VVC_VS_CAP_HDR_OFF    12'h000
`define VVC_VS_HDR_OFF        12'h004
`define VVC_VS_LOOPBACK_OFF   12'h008
`define VVC_VS_STATUS_OFF     12'h00C

// Vendor identification word, absolute byte address
`define VVC_MAKER_CODE_ADDR   12'h000

// Allowed structure bases and next pointer values
`define VVC_BASE_NONE         12'h000
`define VVC_VC_BASE_ALT       12'h10C
`define VVC_VS_BASE_ALT       12'h128
`define VVC_VC_NEXT_ALT       12'h128
`define VVC_NEXT_LAST         12'h000

// Field positions
`define VVC_ID_LSB            0
`define VVC_VER_LSB           16
`define VVC_NEXT_LSB          20
`define VVC_LEN_LSB           20
`define VVC_SNOOP_BIT         15
`define VVC_STAT_VALID_BIT    8

// Fixed identifiers
`define VVC_CHANNEL_CAP_IDENTIFIER         16'h0002
`define VVC_VS_CAP_ID         16'h000B

// Reset values
`define VVC_LOOPBACK_RST      8'h00
`define VVC_INDEX_RST         6'h00

// Data credit counts and last-buffer indices of the allowed pairings
`define VVC_CRED_77           10'd77
`define VVC_CRED_154          10'd154
`define VVC_CRED_308          10'd308
`define VVC_CRED_616          10'd616
`define VVC_IDX_P0_S          6'd25
`define VVC_IDX_P0_L          6'd31
`define VVC_IDX_P1_S          6'd13
`define VVC_IDX_P1_L          6'd28
`define VVC_IDX_P2_S          6'd14
`define VVC_IDX_P2_L          6'd29
`define VVC_IDX_P3_S          6'd14
`define VVC_IDX_P3_L          6'd30

`endif

// ===== vvc_pkg.sv
// Types shared by the capability bank and its credit checker.
// Assumes vvc_regs.svh for all numeric constants.
package vvc_pkg;

    // One configuration access, dword addressed, byte enables active high
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [9:0]  dw_addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } vvc_cfg_req_t;

    // Answer to one access
    typedef struct packed {
        logic        done;
        logic        hit;
        logic [31:0] rdata;
    } vvc_cfg_rsp_t;

    // Which path an access came from
    typedef enum logic {
        VVC_SRC_LINK,
        VVC_SRC_MGMT
    } vvc_src_t;

endpackage

// ===== vvc_credit_check.sv
// Checks the payload / data credit pairing and yields the transmit last-buffer index.
// Assumes static configuration inputs; outputs are registered.
`include "vvc_regs.svh"

module vvc_credit_check
    import vvc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] max_payload_code_i,
    input  wire logic [9:0] completion_data_credits_i,
    input  wire logic [9:0] posted_data_credits_i,
    output logic            valid_o,
    output logic [5:0]      tx_last_buffer_index_o
);

    // Returns {valid, index} for one pairing
    function automatic logic [6:0] lookup(input logic [2:0] code, input logic [9:0] cd,
                                          input logic [9:0] pd);
        logic [6:0] res;
        res = 7'h00;
        if (cd == pd) begin
            case (code)
                3'h0: begin
                    if (cd == `VVC_CRED_77)  res = {1'b1, `VVC_IDX_P0_S};
                    if (cd == `VVC_CRED_154) res = {1'b1, `VVC_IDX_P0_L};
                end
                3'h1: begin
                    if (cd == `VVC_CRED_77)  res = {1'b1, `VVC_IDX_P1_S};
                    if (cd == `VVC_CRED_154) res = {1'b1, `VVC_IDX_P1_L};
                end
                3'h2: begin
                    if (cd == `VVC_CRED_154) res = {1'b1, `VVC_IDX_P2_S};
                    if (cd == `VVC_CRED_308) res = {1'b1, `VVC_IDX_P2_L};
                end
                3'h3: begin
                    if (cd == `VVC_CRED_308) res = {1'b1, `VVC_IDX_P3_S};
                    if (cd == `VVC_CRED_616) res = {1'b1, `VVC_IDX_P3_L};
                end
                default: res = 7'h00;
            endcase
        end
        return res;
    endfunction

    logic [6:0] look;

    assign look = lookup(max_payload_code_i, completion_data_credits_i, posted_data_credits_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o                <= 1'b0;
            tx_last_buffer_index_o <= `VVC_INDEX_RST;
        end else begin
            valid_o                <= look[6];
            tx_last_buffer_index_o <= look[5:0];
        end
    end

endmodule

// ===== vvc_cap_bank.sv
// Capability bank: virtual channel and vendor-specific structures, maker code,
// loopback control and transmit buffer configuration.
// Assumes link and management accesses are synchronous to clk_i, one per cycle each.
//
// Function
// - VC structure base is 000h or 10Ch
// - VC header bits 15:0 carry identifier 0002h
// - VC header bits 19:16 carry version
// - VC next pointer is 128h or 000h
// - Absent VC structure unreachable from both paths
// - Snoop rejection shown in resource capability
// - Vendor structure base is 000h or 128h
// - Vendor header: identifier, revision, byte length
// - Vendor capability identifier 000Bh plus version
// - Link sees vendor structure only when visible
// - Vendor next pointer is always 000h
// - Absent vendor structure unreachable from both paths
// - Last buffer index is buffer count minus one
// - Only listed payload/credit pairings are accepted
// - Maker code returned in vendor identification word unless a structure sits at 000h
`include "vvc_regs.svh"

module vvc_cap_bank
    import vvc_pkg::*;
#(
    parameter logic [11:0] CHANNEL_STRUCT_BASE        = `VVC_VC_BASE_ALT,
    parameter logic [15:0] CHANNEL_CAP_IDENTIFIER     = `VVC_CHANNEL_CAP_IDENTIFIER,
    parameter logic [3:0]  CHANNEL_CAP_VERSION        = 4'h1,
    parameter logic [11:0] CHANNEL_NEXT_CAP_POINTER   = `VVC_VC_NEXT_ALT,
    parameter logic        CHANNEL_STRUCT_PRESENT     = 1'b1,
    parameter logic        REJECT_NO_SNOOP_TLPS       = 1'b0,
    parameter logic [15:0] MAKER_CODE                 = 16'h1234,  // Arbitrary value
    parameter logic [11:0] VENDOR_STRUCT_BASE         = `VVC_VS_BASE_ALT,
    parameter logic [15:0] VENDOR_DEFINED_IDENTIFIER  = 16'h0001,
    parameter logic [3:0]  VENDOR_STRUCT_REVISION     = 4'h0,
    parameter logic [11:0] VENDOR_STRUCT_LENGTH       = 12'h010,
    parameter logic [15:0] VENDOR_CAP_IDENTIFIER      = `VVC_VS_CAP_ID,
    parameter logic [3:0]  VENDOR_CAP_VERSION         = 4'h1,
    parameter logic        VENDOR_STRUCT_LINK_VISIBLE = 1'b1,
    parameter logic        VENDOR_STRUCT_PRESENT      = 1'b1,
    parameter logic [2:0]  MAX_PAYLOAD_CODE           = 3'h0,
    parameter logic [9:0]  COMPLETION_DATA_CREDITS    = `VVC_CRED_77,
    parameter logic [9:0]  POSTED_DATA_CREDITS        = `VVC_CRED_77
) (
    input  wire logic         clk_i,
    input  wire vvc_cfg_req_t link_req_i,
    input  wire vvc_cfg_req_t mgmt_req_i,
    input  wire logic         rst_i,
    output vvc_cfg_rsp_t      link_rsp_o,
    output vvc_cfg_rsp_t      mgmt_rsp_o,
    output logic [7:0]        loopback_ctrl_o,
    output logic              reject_no_snoop_tlps_o,
    output logic [5:0]        tx_last_buffer_index_o,
    output logic              credit_cfg_valid_o
);

    // A structure placed at a base outside its allowed pair is treated as absent
    localparam logic VC_BASE_OK =
        (CHANNEL_STRUCT_BASE == `VVC_BASE_NONE) ||
        (CHANNEL_STRUCT_BASE == `VVC_VC_BASE_ALT);
    localparam logic VS_BASE_OK =
        (VENDOR_STRUCT_BASE == `VVC_BASE_NONE) ||
        (VENDOR_STRUCT_BASE == `VVC_VS_BASE_ALT);
    localparam logic VC_ON = CHANNEL_STRUCT_PRESENT && VC_BASE_OK;
    localparam logic VS_ON = VENDOR_STRUCT_PRESENT && VS_BASE_OK;

    // Next pointer limited to its two legal values, last otherwise
    localparam logic [11:0] VC_NEXT =
        (CHANNEL_NEXT_CAP_POINTER == `VVC_VC_NEXT_ALT) ?
        `VVC_VC_NEXT_ALT : `VVC_NEXT_LAST;

    // Read-only words, built once from configuration
    localparam logic [31:0] VC_HDR_WORD =
        (32'(VC_NEXT) << `VVC_NEXT_LSB) |
        (32'(CHANNEL_CAP_VERSION) << `VVC_VER_LSB) |
        (32'(CHANNEL_CAP_IDENTIFIER) << `VVC_ID_LSB);
    localparam logic [31:0] VC_RES_WORD =
        32'(REJECT_NO_SNOOP_TLPS) << `VVC_SNOOP_BIT;
    localparam logic [31:0] VS_CAP_HDR_WORD =
        (32'(`VVC_NEXT_LAST) << `VVC_NEXT_LSB) |
        (32'(VENDOR_CAP_VERSION) << `VVC_VER_LSB) |
        (32'(VENDOR_CAP_IDENTIFIER) << `VVC_ID_LSB);
    localparam logic [31:0] VS_HDR_WORD =
        (32'(VENDOR_STRUCT_LENGTH) << `VVC_LEN_LSB) |
        (32'(VENDOR_STRUCT_REVISION) << `VVC_VER_LSB) |
        (32'(VENDOR_DEFINED_IDENTIFIER) << `VVC_ID_LSB);
    localparam logic [31:0] MAKER_WORD = 32'(MAKER_CODE);

    logic [7:0] loopback_r;
    logic       chk_valid;
    logic [5:0] chk_index;

    // True when a dword address falls on base plus offset
    function automatic logic at(input logic [9:0] dw, input logic [11:0] base,
                                input logic [11:0] off);
        logic [11:0] sum;
        sum = base + off;
        return dw == sum[11:2];
    endfunction

    // Whether the vendor structure may be reached from a path
    function automatic logic vs_reach(input vvc_src_t src);
        logic ok;
        ok = VS_ON;
        if (src == VVC_SRC_LINK && !VENDOR_STRUCT_LINK_VISIBLE) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // Read decode: returns {hit, data}; structures win over the maker word
    function automatic logic [32:0] read_word(input vvc_src_t src, input logic [9:0] dw);
        logic [32:0] res;
        res = 33'h0_0000_0000;
        if (at(dw, 12'h000, `VVC_MAKER_CODE_ADDR)) begin
            res = {1'b1, MAKER_WORD};
        end
        if (VC_ON) begin
            if (at(dw, CHANNEL_STRUCT_BASE, `VVC_VC_HDR_OFF)) begin
                res = {1'b1, VC_HDR_WORD};
            end else if (at(dw, CHANNEL_STRUCT_BASE, `VVC_VC_PORT_CAP1_OFF) ||
                         at(dw, CHANNEL_STRUCT_BASE, `VVC_VC_PORT_CAP2_OFF) ||
                         at(dw, CHANNEL_STRUCT_BASE, `VVC_VC_PORT_CTRL_OFF)) begin
                res = {1'b1, 32'h0000_0000};
            end else if (at(dw, CHANNEL_STRUCT_BASE, `VVC_VC_RES_CAP_OFF)) begin
                res = {1'b1, VC_RES_WORD};
            end
        end
        if (vs_reach(src)) begin
            if (at(dw, VENDOR_STRUCT_BASE, `VVC_VS_CAP_HDR_OFF)) begin
                res = {1'b1, VS_CAP_HDR_WORD};
            end else if (at(dw, VENDOR_STRUCT_BASE, `VVC_VS_HDR_OFF)) begin
                res = {1'b1, VS_HDR_WORD};
            end else if (at(dw, VENDOR_STRUCT_BASE, `VVC_VS_LOOPBACK_OFF)) begin
                res = {1'b1, 24'h00_0000, loopback_r};
            end else if (at(dw, VENDOR_STRUCT_BASE, `VVC_VS_STATUS_OFF)) begin
                res = {1'b1, 23'h00_0000, chk_valid, 2'h0, chk_index};
            end
        end
        return res;
    endfunction

    // True for a write that lands on the loopback control byte
    function automatic logic lb_write(input vvc_src_t src, input vvc_cfg_req_t rq);
        return rq.wr && rq.be[0] && vs_reach(src) &&
               at(rq.dw_addr, VENDOR_STRUCT_BASE, `VVC_VS_LOOPBACK_OFF);
    endfunction

    logic [32:0] link_rd;
    logic [32:0] mgmt_rd;

    assign link_rd = read_word(VVC_SRC_LINK, link_req_i.dw_addr);
    assign mgmt_rd = read_word(VVC_SRC_MGMT, mgmt_req_i.dw_addr);

    // Loopback control is the only writable field; the link path wins a collision
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loopback_r <= `VVC_LOOPBACK_RST;
        end else if (lb_write(VVC_SRC_LINK, link_req_i)) begin
            loopback_r <= link_req_i.wdata[7:0];
        end else if (lb_write(VVC_SRC_MGMT, mgmt_req_i)) begin
            loopback_r <= mgmt_req_i.wdata[7:0];
        end
    end

    // Link path answer, one cycle after the access; header writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_rsp_o <= '0;
        end else begin
            link_rsp_o.done  <= link_req_i.rd | link_req_i.wr;
            link_rsp_o.hit   <= (link_req_i.rd | link_req_i.wr) & link_rd[32];
            link_rsp_o.rdata <= link_req_i.rd ? link_rd[31:0] : 32'h0000_0000;
        end
    end

    // Management path answer, same timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mgmt_rsp_o <= '0;
        end else begin
            mgmt_rsp_o.done  <= mgmt_req_i.rd | mgmt_req_i.wr;
            mgmt_rsp_o.hit   <= (mgmt_req_i.rd | mgmt_req_i.wr) & mgmt_rd[32];
            mgmt_rsp_o.rdata <= mgmt_req_i.rd ? mgmt_rd[31:0] : 32'h0000_0000;
        end
    end

    vvc_credit_check u_credit (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .max_payload_code_i       (MAX_PAYLOAD_CODE),
        .completion_data_credits_i(COMPLETION_DATA_CREDITS),
        .posted_data_credits_i    (POSTED_DATA_CREDITS),
        .valid_o                  (chk_valid),
        .tx_last_buffer_index_o   (chk_index)
    );

    // Exported configuration; an unlisted pairing forces index zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loopback_ctrl_o        <= `VVC_LOOPBACK_RST;
            reject_no_snoop_tlps_o <= 1'b0;
            tx_last_buffer_index_o <= `VVC_INDEX_RST;
            credit_cfg_valid_o     <= 1'b0;
        end else begin
            loopback_ctrl_o        <= loopback_r;
            reject_no_snoop_tlps_o <= REJECT_NO_SNOOP_TLPS;
            tx_last_buffer_index_o <= chk_valid ? chk_index : `VVC_INDEX_RST;
            credit_cfg_valid_o     <= chk_valid;
        end
    end

endmodule

// ===== vvc_cap_bank_asserts.sv
// Concurrent checks on the ports of the capability bank.
// Assumes one clock domain; bound into every bank instance.
`include "vvc_regs.svh"

module vvc_cap_bank_asserts
    import vvc_pkg::*;
#(
    parameter logic       REJECT_NO_SNOOP_TLPS    = 1'b0,
    parameter logic [2:0] MAX_PAYLOAD_CODE        = 3'h0,
    parameter logic [9:0] COMPLETION_DATA_CREDITS = `VVC_CRED_77,
    parameter logic [9:0] POSTED_DATA_CREDITS     = `VVC_CRED_77
) (
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire vvc_cfg_req_t link_req_i,
    input wire vvc_cfg_req_t mgmt_req_i,
    input wire vvc_cfg_rsp_t link_rsp_o,
    input wire vvc_cfg_rsp_t mgmt_rsp_o,
    input wire logic [7:0]   loopback_ctrl_o,
    input wire logic         reject_no_snoop_tlps_o,
    input wire logic [5:0]   tx_last_buffer_index_o,
    input wire logic         credit_cfg_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    function automatic logic [5:0] idx_of(logic [2:0] p, logic [9:0] c);
        case ({p, c})
            {3'h0, `VVC_CRED_77}:  return `VVC_IDX_P0_S;
            {3'h0, `VVC_CRED_154}: return `VVC_IDX_P0_L;
            {3'h1, `VVC_CRED_77}:  return `VVC_IDX_P1_S;
            {3'h1, `VVC_CRED_154}: return `VVC_IDX_P1_L;
            {3'h2, `VVC_CRED_154}: return `VVC_IDX_P2_S;
            {3'h2, `VVC_CRED_308}: return `VVC_IDX_P2_L;
            {3'h3, `VVC_CRED_308}: return `VVC_IDX_P3_S;
            {3'h3, `VVC_CRED_616}: return `VVC_IDX_P3_L;
            default:               return 6'h00;
        endcase
    endfunction

    // Unlisted or unequal credit pairings expect index 0 and no valid flag
    localparam logic [5:0] EXP_IDX = (COMPLETION_DATA_CREDITS != POSTED_DATA_CREDITS) ?
        6'h00 : idx_of(MAX_PAYLOAD_CODE, COMPLETION_DATA_CREDITS);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_link_req;
        link_req_i.rd || link_req_i.wr;
    endsequence
    sequence s_mgmt_req;
        mgmt_req_i.rd || mgmt_req_i.wr;
    endsequence

    a_link_answer: assert property (s_link_req |=> link_rsp_o.done)
        else $error("link access without done one cycle later");
    a_mgmt_answer: assert property (s_mgmt_req |=> mgmt_rsp_o.done)
        else $error("mgmt access without done one cycle later");
    a_done_cause: assert property (link_rsp_o.done |-> $past(link_req_i.rd || link_req_i.wr))
        else $error("link done without a request");
    a_hit_with_done: assert property ((link_rsp_o.hit |-> link_rsp_o.done)
        and (mgmt_rsp_o.hit |-> mgmt_rsp_o.done)) else $error("hit outside done");
    a_miss_zero: assert property (link_rsp_o.done && !link_rsp_o.hit |->
        link_rsp_o.rdata == 32'h0) else $error("refused link access returned data");
    a_write_quiet: assert property (mgmt_req_i.wr |=> mgmt_rsp_o.rdata == 32'h0)
        else $error("mgmt write returned data");
    a_snoop_level: assert property (!$past(rst_i) |->
        reject_no_snoop_tlps_o == REJECT_NO_SNOOP_TLPS) else $error("snoop flag wrong");
    a_credit_table: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
        tx_last_buffer_index_o == EXP_IDX && credit_cfg_valid_o == (EXP_IDX != 6'h00))
        else $error("buffer index or credit valid wrong");
    a_loop_cause: assert property ($changed(loopback_ctrl_o) |->
        $past(link_req_i.wr || mgmt_req_i.wr, 2)) else $error("loopback moved without write");
endmodule

// ===== vvc_cfg_partner.sv
// Requester model for the link partner and the user management port of one bank.
// Assumes xfer is called by one process per path; accesses are spaced by a gap cycle.
module vvc_cfg_partner
    import vvc_pkg::*;
(
    input  wire logic         clk_i,
    input  wire vvc_cfg_rsp_t link_rsp_i,
    input  wire vvc_cfg_rsp_t mgmt_rsp_i,
    output vvc_cfg_req_t      link_req_o,
    output vvc_cfg_req_t      mgmt_req_o
);
    timeunit 1ns;
    timeprecision 1ps;

    vvc_cfg_req_t req_q [2] = '{default: '0};

    assign link_req_o = req_q[0];
    assign mgmt_req_o = req_q[1];

    // Held over one rising edge; idle lines carry inverted leftovers
    task automatic xfer(input vvc_src_t s, input logic w, input logic [9:0] dw,
                        input logic [3:0] be, input logic [31:0] wd, output vvc_cfg_rsp_t r);
        @(negedge clk_i);
        req_q[s] = '{rd: !w, wr: w, dw_addr: dw, be: be, wdata: wd};
        @(posedge clk_i);
        @(negedge clk_i);
        r = (s == VVC_SRC_MGMT) ? mgmt_rsp_i : link_rsp_i;
        req_q[s] = '{rd: 1'h0, wr: 1'h0, dw_addr: ~dw, be: ~be, wdata: ~wd};
    endtask
endmodule

// ===== vc_vsec_capability_config_tb.sv
// Self-checking bench: three bank builds, table-driven accesses, then hand-made cases.
// Assumes the requester model drives both access paths of every bank.
`include "vvc_regs.svh"

module vc_vsec_capability_config_tb
    import vvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int k; vvc_src_t src; logic wr; logic [9:0] dw; logic [3:0] be;
        logic [31:0] wd; logic hit; logic [31:0] rd;
    } vvc_row_t;

    localparam vvc_src_t LNK = VVC_SRC_LINK;
    localparam vvc_src_t MGT = VVC_SRC_MGMT;

    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    vvc_cfg_req_t lreq [3];
    vvc_cfg_req_t mreq [3];
    vvc_cfg_rsp_t lrsp [3];
    vvc_cfg_rsp_t mrsp [3];
    logic [7:0]   loop_o [3];
    logic         snoop_o [3];
    logic [5:0]   idx_o [3];
    logic         valid_o [3];
    logic [5:0]   exp_idx [3] = '{`VVC_IDX_P0_S, `VVC_IDX_P3_L, 6'h00};
    vvc_cfg_rsp_t r1;
    vvc_cfg_rsp_t r2;
    int           err_total = 0;
    int           num_checks = 0;
    int           cyc = 0;

    // Build 0 defaults; 1 low VC base, hidden vendor; 2 both absent, bad pairing
    vvc_row_t rows [20] = '{
        '{0, LNK, 1'h0, 10'h000, 4'hF, 32'h0, 1'h1, 32'h0000_1234},
        '{0, LNK, 1'h0, 10'h043, 4'hF, 32'h0, 1'h1, 32'h1281_0002},
        '{0, MGT, 1'h0, 10'h043, 4'hF, 32'h0, 1'h1, 32'h1281_0002},
        '{0, LNK, 1'h0, 10'h047, 4'hF, 32'h0, 1'h1, 32'h0000_0000},
        '{0, LNK, 1'h0, 10'h04A, 4'hF, 32'h0, 1'h1, 32'h0001_000B},
        '{0, MGT, 1'h0, 10'h04B, 4'hF, 32'h0, 1'h1, 32'h0100_0001},
        '{0, LNK, 1'h1, 10'h043, 4'hF, 32'hFFFF_FFFF, 1'h1, 32'h0},
        '{0, LNK, 1'h0, 10'h043, 4'hF, 32'h0, 1'h1, 32'h1281_0002},
        '{0, MGT, 1'h1, 10'h04C, 4'h1, 32'h0000_00A5, 1'h1, 32'h0},
        '{0, LNK, 1'h1, 10'h04C, 4'hE, 32'h0000_005A, 1'h1, 32'h0},
        '{0, LNK, 1'h0, 10'h04C, 4'hF, 32'h0, 1'h1, 32'h0000_00A5},
        '{0, MGT, 1'h0, 10'h04D, 4'hF, 32'h0, 1'h1, 32'h0000_0119},
        '{0, LNK, 1'h0, 10'h080, 4'hF, 32'h0, 1'h0, 32'h0},
        '{1, LNK, 1'h0, 10'h000, 4'hF, 32'h0, 1'h1, 32'h0001_0002},
        '{1, MGT, 1'h0, 10'h004, 4'hF, 32'h0, 1'h1, 32'h0000_8000},
        '{1, LNK, 1'h0, 10'h04A, 4'hF, 32'h0, 1'h0, 32'h0},
        '{1, MGT, 1'h0, 10'h04A, 4'hF, 32'h0, 1'h1, 32'h0001_000B},
        '{2, LNK, 1'h0, 10'h043, 4'hF, 32'h0, 1'h0, 32'h0},
        '{2, MGT, 1'h0, 10'h043, 4'hF, 32'h0, 1'h0, 32'h0},
        '{2, MGT, 1'h0, 10'h04A, 4'hF, 32'h0, 1'h0, 32'h0}
    };

    for (genvar g = 0; g < 3; g++) begin : gb
        vvc_cap_bank #(
            .CHANNEL_STRUCT_BASE       (g == 1 ? `VVC_BASE_NONE : `VVC_VC_BASE_ALT),
            .CHANNEL_NEXT_CAP_POINTER  (g == 1 ? `VVC_NEXT_LAST : `VVC_VC_NEXT_ALT),
            .CHANNEL_STRUCT_PRESENT    (g != 2),
            .REJECT_NO_SNOOP_TLPS      (g == 1),
            .VENDOR_STRUCT_LINK_VISIBLE(g != 1),
            .VENDOR_STRUCT_PRESENT     (g != 2),
            .MAX_PAYLOAD_CODE          (g == 0 ? 3'h0 : (g == 1 ? 3'h3 : 3'h1)),
            .COMPLETION_DATA_CREDITS   (g == 0 ? `VVC_CRED_77 : `VVC_CRED_616),
            .POSTED_DATA_CREDITS       (g == 0 ? `VVC_CRED_77 : `VVC_CRED_616)
        ) vvc_cap_bank_i (
            .clk_i(clk_i), .link_req_i(lreq[g]), .mgmt_req_i(mreq[g]), .rst_i(rst_i),
            .link_rsp_o(lrsp[g]), .mgmt_rsp_o(mrsp[g]), .loopback_ctrl_o(loop_o[g]),
            .reject_no_snoop_tlps_o(snoop_o[g]), .tx_last_buffer_index_o(idx_o[g]),
            .credit_cfg_valid_o(valid_o[g])
        );
        vvc_cfg_partner vvc_cfg_partner_i (
            .clk_i(clk_i), .link_rsp_i(lrsp[g]), .mgmt_rsp_i(mrsp[g]),
            .link_req_o(lreq[g]), .mgmt_req_o(mreq[g])
        );
    end

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input int k, input vvc_src_t s, input logic w, input logic [9:0] dw,
                        input logic [3:0] be, input logic [31:0] wd, output vvc_cfg_rsp_t r);
        case (k)
            0: gb[0].vvc_cfg_partner_i.xfer(s, w, dw, be, wd, r);
            1: gb[1].vvc_cfg_partner_i.xfer(s, w, dw, be, wd, r);
            default: gb[2].vvc_cfg_partner_i.xfer(s, w, dw, be, wd, r);
        endcase
    endtask

    initial begin
        repeat (10) @(negedge clk_i);
        check("done in reset", 32'h0, lrsp[0].done);
        check("loopback in reset", `VVC_LOOPBACK_RST, loop_o[0]);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        for (int k = 0; k < 3; k++) begin
            check("snoop flag", k == 1, snoop_o[k]);
            check("credit valid", k != 2, valid_o[k]);
            check("last buffer index", exp_idx[k], idx_o[k]);
        end
        $display("test static outputs done");
        foreach (rows[i]) begin
            xfer(rows[i].k, rows[i].src, rows[i].wr, rows[i].dw, rows[i].be, rows[i].wd, r1);
            check($sformatf("row %0d done", i), 32'h1, r1.done);
            check($sformatf("row %0d hit", i), rows[i].hit, r1.hit);
            check($sformatf("row %0d rdata", i), rows[i].rd, r1.rdata);
        end
        check("loopback output", 32'hA5, loop_o[0]);
        $display("test access table done");
        fork
            xfer(0, LNK, 1'h1, 10'h04C, 4'h1, 32'h0000_005A, r1);
            xfer(0, MGT, 1'h1, 10'h04C, 4'h1, 32'h0000_003C, r2);
        join
        @(negedge clk_i);
        check("same-cycle loopback writes", 32'h5A, loop_o[0]);
        $display("test write collision done");
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("loopback after reset", `VVC_LOOPBACK_RST, loop_o[0]);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        xfer(0, LNK, 1'h0, 10'h04D, 4'hF, 32'h0, r1);
        check("status after reset", 32'h0000_0119, r1.rdata);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule

bind vvc_cap_bank vvc_cap_bank_asserts #(
    .REJECT_NO_SNOOP_TLPS   (REJECT_NO_SNOOP_TLPS),
    .MAX_PAYLOAD_CODE       (MAX_PAYLOAD_CODE),
    .COMPLETION_DATA_CREDITS(COMPLETION_DATA_CREDITS),
    .POSTED_DATA_CREDITS    (POSTED_DATA_CREDITS)
) vvc_cap_bank_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .link_req_i(link_req_i), .mgmt_req_i(mgmt_req_i),
    .link_rsp_o(link_rsp_o), .mgmt_rsp_o(mgmt_rsp_o), .loopback_ctrl_o(loopback_ctrl_o),
    .reject_no_snoop_tlps_o(reject_no_snoop_tlps_o),
    .tx_last_buffer_index_o(tx_last_buffer_index_o), .credit_cfg_valid_o(credit_cfg_valid_o)
);
